// *** hw/monitor_pkg.sv ***
// constants and carrier types for the monitor configuration block
package monitor_pkg;
   // ****************************************************************
   // register addresses
   // ****************************************************************
   localparam logic [7:0] ADDR_CONFIG = 8'h40;
   localparam logic [7:0] ADDR_STAT1  = 8'h41;
   localparam logic [7:0] ADDR_STAT2  = 8'h42;
   localparam logic [7:0] ADDR_MASK1  = 8'h43;
   localparam logic [7:0] ADDR_MASK2  = 8'h44;
   localparam logic [7:0] ADDR_COMPAT = 8'h45;
   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] CONFIG_RST = 8'h08;
   localparam logic [7:0] STAT_RST   = 8'h00;
   localparam logic [7:0] MASK_RST   = 8'h00;
   localparam logic [7:0] COMPAT_RST = 8'h00;
   // ****************************************************************
   // configuration fields
   // ****************************************************************
   localparam int CFG_RUN    = 0;
   localparam int CFG_INT_EN = 1;
   localparam int CFG_CLEAR  = 3;
   localparam int CFG_RSTREQ = 4;
   localparam int CFG_INTRQ  = 6;
   localparam int CFG_INIT   = 7;
   // bits of configuration that hold state
   localparam logic [7:0] CFG_STORED = 8'h0B;
   // ****************************************************************
   // status and mask fields
   // ****************************************************************
   localparam int ST1_TEMP  = 4;
   localparam int ST1_FAN1  = 6;
   localparam int ST1_FAN2  = 7;
   localparam int ST2_INTR  = 4;
   localparam int MSK2_RSTEN = 7;
   localparam logic [7:0] ST1_VALID = 8'hDF;
   localparam logic [7:0] ST2_VALID = 8'h13;
   // ****************************************************************
   // pulse timing
   // ****************************************************************
   localparam int PULSE_MS     = 20;
   localparam int CLK_KHZ      = 125000;
   localparam int PULSE_CYCLES = PULSE_MS * CLK_KHZ;
   localparam int CNT_W        = 22;
   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   // one-cycle compare results, volt order 2.5, core1, 3.3, 5, 12, core2
   typedef struct packed {
      logic [5:0] volt_fail;
      logic       temp_fail;
      logic [1:0] fan_fail;
   } mon_event_t;
endpackage : monitor_pkg

// *** hw/monitor_config_interrupt_control.sv ***
// configuration, status, mask and interrupt logic of the hardware monitor
`timescale 1ns/1ps
module monitor_config_interrupt_control #(
   parameter int PULSE_LEN = monitor_pkg::PULSE_CYCLES
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   nrst,
   // register access
   input  wire monitor_pkg::reg_req_t  req,
   output      logic [7:0]             rdata_r,
   output      logic                   rvalid_r,
   // monitoring engine
   input  wire monitor_pkg::mon_event_t events,
   output      logic                   monitor_en_r,
   output      logic                   soft_init_r,
   // pins
   output      logic                   int_n_r,
   output      logic                   reset_n_r,
   input  wire logic                   intrusion_in,
   output      logic                   intrusion_out_r,
   output      logic                   intrusion_oe_r
);
   import monitor_pkg::*;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [CNT_W-1:0] pulse_count(
      input logic            start,
      input logic [CNT_W-1:0] cnt
   );
      if (start) begin
         return CNT_W'(PULSE_LEN - 1);
      end else if (cnt != '0) begin
         return cnt - CNT_W'(1);
      end
      return '0;
   endfunction : pulse_count

   function automatic logic reg_write(
      input reg_req_t   r,
      input logic [7:0] a
   );
      return r.wr && (r.addr == a);
   endfunction : reg_write

   // ****************************************************************
   // state
   // ****************************************************************
   logic [7:0]       cfg_r,    cfg_nxt;
   logic [7:0]       stat1_r,  stat1_nxt;
   logic [7:0]       stat2_r,  stat2_nxt;
   logic [7:0]       mask1_r,  mask1_nxt;
   logic [7:0]       mask2_r,  mask2_nxt;
   logic [7:0]       compat_r, compat_nxt;
   logic [7:0]       rdata_nxt;
   logic             rvalid_nxt;
   logic             monitor_en_nxt;
   logic             soft_init_nxt;
   logic             int_n_nxt;
   logic [CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;
   logic [CNT_W-1:0] intr_cnt_r, intr_cnt_nxt;
   logic             reset_n_nxt;
   logic             intrusion_oe_nxt;
   logic             intr_prev_r, intr_prev_nxt;
   logic             cfg_wr;
   logic             init_req;
   logic             rst_start;
   logic             intr_start;
   logic             active;
   logic [7:0]       set1;
   logic [7:0]       set2;
   logic [7:0]       clr1;
   logic [7:0]       clr2;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      cfg_wr   = reg_write(req, ADDR_CONFIG);
      init_req = cfg_wr && req.wdata[CFG_INIT];
      active   = cfg_r[CFG_RUN] && !cfg_r[CFG_CLEAR];
      rst_start  = cfg_wr && req.wdata[CFG_RSTREQ] && mask2_r[MSK2_RSTEN];
      intr_start = cfg_wr && req.wdata[CFG_INTRQ];

      set1 = '0;
      set2 = '0;
      set1[3:0] = events.volt_fail[3:0];
      set2[1:0] = events.volt_fail[5:4];
      set1[ST1_TEMP] = events.temp_fail;
      set1[ST1_FAN1] = events.fan_fail[0];
      set1[ST1_FAN2] = events.fan_fail[1];
      set2[ST2_INTR] = intrusion_in && !intr_prev_r;
      if (!active) begin
         set1 = '0;
         set2 = '0;
      end
      set1 = set1 & ST1_VALID;
      set2 = set2 & ST2_VALID;

      clr1 = (req.rd && req.addr == ADDR_STAT1) ? stat1_r : '0;
      clr2 = (req.rd && req.addr == ADDR_STAT2) ? stat2_r : '0;
      // new event wins over the read clear
      stat1_nxt = (stat1_r & ~clr1) | set1;
      stat2_nxt = (stat2_r & ~clr2) | set2;

      cfg_nxt    = cfg_r;
      mask1_nxt  = mask1_r;
      mask2_nxt  = mask2_r;
      compat_nxt = compat_r;
      if (cfg_wr) begin
         cfg_nxt = req.wdata & CFG_STORED;
      end
      if (reg_write(req, ADDR_MASK1)) begin
         mask1_nxt = req.wdata;
      end
      if (reg_write(req, ADDR_MASK2)) begin
         mask2_nxt = req.wdata;
      end
      if (reg_write(req, ADDR_COMPAT)) begin
         compat_nxt = req.wdata;
      end
      if (init_req) begin
         cfg_nxt   = CONFIG_RST;
         stat1_nxt = STAT_RST;
         stat2_nxt = STAT_RST;
         mask1_nxt = MASK_RST;
         mask2_nxt = MASK_RST;
      end

      rvalid_nxt = req.rd;
      rdata_nxt  = '0;
      if (req.rd) begin
         case (req.addr)
            ADDR_CONFIG: rdata_nxt = cfg_r;
            ADDR_STAT1:  rdata_nxt = stat1_r;
            ADDR_STAT2:  rdata_nxt = stat2_r;
            ADDR_MASK1:  rdata_nxt = mask1_r;
            ADDR_MASK2:  rdata_nxt = mask2_r;
            ADDR_COMPAT: rdata_nxt = compat_r;
            default:     rdata_nxt = '0;
         endcase
      end

      monitor_en_nxt = cfg_nxt[CFG_RUN] && !cfg_nxt[CFG_CLEAR];
      soft_init_nxt  = init_req;
      // clear bit, masks, int enable off or a status read release it, not run off
      int_n_nxt = !(cfg_r[CFG_INT_EN] && !cfg_r[CFG_CLEAR] &&
                    (|(stat1_r & ~mask1_r & ST1_VALID) ||
                     |(stat2_r & ~mask2_r & ST2_VALID)));

      rst_cnt_nxt = pulse_count(rst_start, rst_cnt_r);
      reset_n_nxt = !(rst_start || (!reset_n_r && rst_cnt_r != '0));
      intr_cnt_nxt     = pulse_count(intr_start, intr_cnt_r);
      intrusion_oe_nxt = intr_start || (intrusion_oe_r && intr_cnt_r != '0);
      // own drive low must not read as an intrusion on release
      intr_prev_nxt = intrusion_in || intrusion_oe_r;
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cfg_r           <= CONFIG_RST;
         stat1_r         <= STAT_RST;
         stat2_r         <= STAT_RST;
         mask1_r         <= MASK_RST;
         mask2_r         <= MASK_RST;
         compat_r        <= COMPAT_RST;
         rdata_r         <= '0;
         rvalid_r        <= 1'b0;
         monitor_en_r    <= 1'b0;
         soft_init_r     <= 1'b0;
         int_n_r         <= 1'b1;
         rst_cnt_r       <= '0;
         intr_cnt_r      <= '0;
         reset_n_r       <= 1'b1;
         intrusion_oe_r  <= 1'b0;
         intrusion_out_r <= 1'b0;
         intr_prev_r     <= 1'b1;
      end else begin
         cfg_r           <= cfg_nxt;
         stat1_r         <= stat1_nxt;
         stat2_r         <= stat2_nxt;
         mask1_r         <= mask1_nxt;
         mask2_r         <= mask2_nxt;
         compat_r        <= compat_nxt;
         rdata_r         <= rdata_nxt;
         rvalid_r        <= rvalid_nxt;
         monitor_en_r    <= monitor_en_nxt;
         soft_init_r     <= soft_init_nxt;
         int_n_r         <= int_n_nxt;
         rst_cnt_r       <= rst_cnt_nxt;
         intr_cnt_r      <= intr_cnt_nxt;
         reset_n_r       <= reset_n_nxt;
         intrusion_oe_r  <= intrusion_oe_nxt;
         intrusion_out_r <= 1'b0;
         intr_prev_r     <= intr_prev_nxt;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // cycles each pulse output has been active, for the width checks
   logic [CNT_W-1:0] rst_low_r,  rst_low_nxt;
   logic [CNT_W-1:0] intr_low_r, intr_low_nxt;

   always_comb begin
      rst_low_nxt  = reset_n_r ? '0 : rst_low_r + CNT_W'(1);
      intr_low_nxt = intrusion_oe_r ? intr_low_r + CNT_W'(1) : '0;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rst_low_r  <= '0;
         intr_low_r <= '0;
      end else begin
         rst_low_r  <= rst_low_nxt;
         intr_low_r <= intr_low_nxt;
      end
   end

   sequence cfg_write_s(int b);
      req.wr && req.addr == ADDR_CONFIG && req.wdata[b];
   endsequence

   start_run_a: assert property (
      req.wr && req.addr == ADDR_CONFIG && req.wdata[CFG_RUN] &&
      !req.wdata[CFG_CLEAR] && !req.wdata[CFG_INIT] |=> monitor_en_r)
      else $error("run write did not start monitoring");
   run_off_a: assert property (
      !int_n_r && !cfg_r[CFG_CLEAR] && !cfg_r[CFG_RUN] &&
      !req.wr && !req.rd |=> !int_n_r)
      else $error("interrupt released without clear");
   int_gate_a: assert property (
      !cfg_r[CFG_INT_EN] |=> int_n_r)
      else $error("interrupt asserted while disabled");
   clear_hold_a: assert property (
      cfg_r[CFG_CLEAR] && !req.wr && !req.rd
      |=> int_n_r && $stable(stat1_r) && $stable(stat2_r))
      else $error("clear bit did not freeze status");
   rst_len_a: assert property (
      $fell(reset_n_r) |-> !reset_n_r [*2])
      else $error("reset pulse too short");
   rst_gate_a: assert property (
      cfg_write_s(CFG_RSTREQ) and (reset_n_r && !mask2_r[MSK2_RSTEN])
      |=> reset_n_r)
      else $error("reset pulse without enable");
   intr_pulse_a: assert property (
      cfg_write_s(CFG_INTRQ) |=> intrusion_oe_r && !intrusion_out_r)
      else $error("intrusion pulse not driven");
   soft_init_a: assert property (
      cfg_write_s(CFG_INIT) |=> cfg_r == CONFIG_RST &&
      stat1_r == STAT_RST && mask2_r == MASK_RST && soft_init_r)
      else $error("soft init did not restore defaults");
   volt_set_a: assert property (
      active && events.volt_fail[4] |=> stat2_r[0])
      else $error("voltage flag not set");
   read_clear_a: assert property (
      req.rd && req.addr == ADDR_STAT1 && !active && !req.wr
      |=> stat1_r == STAT_RST ##1 stat1_r == STAT_RST)
      else $error("status read did not clear");
   int_raise_a: assert property (
      cfg_r[CFG_INT_EN] && !cfg_r[CFG_CLEAR] &&
      |(stat1_r & ~mask1_r & ST1_VALID) |=> !int_n_r)
      else $error("unmasked flag did not raise interrupt");
   rst_width_a: assert property (
      $rose(reset_n_r) |-> rst_low_r >= CNT_W'(PULSE_LEN))
      else $error("reset pulse shorter than its length");
   intr_width_a: assert property (
      $fell(intrusion_oe_r) |-> intr_low_r >= CNT_W'(PULSE_LEN))
      else $error("intrusion pulse shorter than its length");
   intr_set_a: assert property (
      active && intrusion_in && !intr_prev_r && !init_req
      |=> stat2_r[ST2_INTR])
      else $error("intrusion flag not set");
   fan_set_a: assert property (
      active && events.fan_fail[1] && !init_req |=> stat1_r[ST1_FAN2])
      else $error("fan flag not set");
   mask_gate_a: assert property (
      (stat1_r & ~mask1_r) == '0 && (stat2_r & ~mask2_r) == '0
      |=> int_n_r)
      else $error("masked flag raised interrupt");
endmodule : monitor_config_interrupt_control

// *** sim/mon_host.sv ***
// host model that reaches the registers over the request port
`timescale 1ns/1ps
module mon_host (
   // clock
   input  wire logic                  clk,
   // register port
   output      monitor_pkg::reg_req_t req,
   input  wire logic [7:0]            rdata_r,
   input  wire logic                  rvalid_r
);
   import monitor_pkg::*;
   initial req = '{1'b0, 1'b0, 8'hA5, 8'h5A};
   // one-cycle write strobe, idle lines scrambled afterwards
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      @(posedge clk) #1 req = '{1'b1, 1'b0, a, dat};
      @(posedge clk) #1 req = '{1'b0, 1'b0, ~a, ~dat};
   endtask : wr
   // read data is taken in the cycle that rvalid_r stands
   task automatic rd(input logic [7:0] a, output logic [7:0] dat);
      @(posedge clk) #1 req = '{1'b0, 1'b1, a, 8'h3C};
      @(posedge clk) #1 req = '{1'b0, 1'b0, ~a, 8'hC3};
      dat = rvalid_r ? rdata_r : 8'hXX;
   endtask : rd
endmodule : mon_host

// *** sim/monitor_config_interrupt_control_tb.sv ***
// self-checking bench for the monitor configuration block
`timescale 1ns/1ps
module monitor_config_interrupt_control_tb;
   import monitor_pkg::*;
   localparam int PLEN = 12;
   logic       clk, nrst, intrusion_in, ii;
   logic       rvalid_r, monitor_en_r, soft_init_r, int_n_r, reset_n_r;
   logic       intrusion_out_r, intrusion_oe_r;
   logic [7:0] rdata_r, d, m1, m2, s1, s2;
   mon_event_t events, e;
   reg_req_t   req;
   int         failures, num_checks, cycles, seed, n;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   monitor_config_interrupt_control #(.PULSE_LEN(PLEN)) dut (
      .clk(clk), .nrst(nrst), .req(req), .rdata_r(rdata_r),
      .rvalid_r(rvalid_r), .events(events), .monitor_en_r(monitor_en_r),
      .soft_init_r(soft_init_r), .int_n_r(int_n_r), .reset_n_r(reset_n_r),
      .intrusion_in(intrusion_in), .intrusion_out_r(intrusion_out_r),
      .intrusion_oe_r(intrusion_oe_r));
   mon_host h (.clk(clk), .req(req), .rdata_r(rdata_r), .rvalid_r(rvalid_r));

   // ****************************************************************
   // checking and expectations
   // ****************************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   function automatic logic [7:0] st1(input mon_event_t v);
      return {v.fan_fail, 1'b0, v.temp_fail, v.volt_fail[3:0]};
   endfunction : st1
   function automatic logic [7:0] st2(input mon_event_t v, input logic i);
      return {3'b000, i, 2'b00, v.volt_fail[5:4]};
   endfunction : st2
   function automatic logic irq(input logic [7:0] a, b, ma, mb);
      return |((a & ~ma & ST1_VALID) | (b & ~mb & ST2_VALID));
   endfunction : irq
   task automatic fire(input mon_event_t v, input logic i);
      @(posedge clk) #1 events = v;
      intrusion_in = i;
      @(posedge clk) #1 events = '0;
      intrusion_in = 1'b0;
   endtask : fire
   task automatic wait1;
      @(posedge clk) #1;
   endtask : wait1
   // counts the cycles an output pulse stays active
   task automatic plen(input logic rst);
      n = 0;
      while ((rst ? !reset_n_r : intrusion_oe_r) && n < 100) begin
         n++;
         wait1();
      end
      check(8'(n), 8'(PLEN));
   endtask : plen

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      seed = 72871;
      nrst = 1'b0;
      events = '0;
      intrusion_in = 1'b0;
      failures = 0;
      num_checks = 0;
      cycles = 0;
      repeat (8) @(posedge clk);
      #1 nrst = 1'b1;
      check({int_n_r, reset_n_r, intrusion_oe_r}, 8'h06);
      h.rd(ADDR_CONFIG, d);
      check(d, CONFIG_RST);
      for (int a = 8'h41; a <= 8'h46; a++) begin
         h.rd(8'(a), d);
         check(d, 8'h00);
      end
      m1 = 8'($random(seed));
      h.wr(ADDR_COMPAT, m1);
      h.rd(ADDR_COMPAT, d);
      check(d, m1);
      fire('1, 1'b1);
      h.rd(ADDR_STAT1, d);
      check(d, 8'h00);
      check(8'(monitor_en_r), 8'h00);
      h.wr(ADDR_CONFIG, 8'h03);
      wait1();
      check(8'(monitor_en_r), 8'h01);
      for (int k = 0; k < 8; k++) begin
         m1 = 8'($random(seed));
         m2 = 8'($random(seed)) & 8'h7F;
         e = 9'($random(seed));
         ii = 1'($random(seed));
         if (k == 0) begin
            m1 = 8'h00;
            m2 = 8'h00;
            e = '1;
            ii = 1'b1;
         end else if (k == 1) begin
            m1 = 8'hFF;
            m2 = 8'h13;
            e = '1;
            ii = 1'b1;
         end
         h.wr(ADDR_MASK1, m1);
         h.wr(ADDR_MASK2, m2);
         h.rd(ADDR_MASK1, d);
         check(d, m1);
         h.rd(ADDR_MASK2, d);
         check(d, m2);
         s1 = st1(e);
         s2 = st2(e, ii);
         fire(e, ii);
         wait1();
         check(8'(int_n_r), 8'(!irq(s1, s2, m1, m2)));
         h.rd(ADDR_STAT1, d);
         check(d, s1);
         check(8'(d[ST1_FAN2:ST1_FAN1]), 8'(e.fan_fail));
         h.rd(ADDR_STAT2, d);
         check(d, s2);
         h.rd(ADDR_STAT1, d);
         check(d, 8'h00);
      end
      h.wr(ADDR_MASK1, 8'h00);
      h.wr(ADDR_MASK2, 8'h00);
      // temperature condition alone
      fire(9'h004, 1'b0);
      wait1();
      check(8'(int_n_r), 8'h00);
      h.wr(ADDR_CONFIG, 8'h02);
      wait1();
      check(8'(int_n_r), 8'h00);
      h.wr(ADDR_CONFIG, 8'h0A);
      wait1();
      check(8'(int_n_r), 8'h01);
      // this voltage event must be dropped while cleared
      fire(9'h008, 1'b0);
      h.rd(ADDR_STAT1, d);
      check(d, 8'h10);
      h.wr(ADDR_CONFIG, 8'h01);
      fire(9'h010, 1'b0);
      wait1();
      check(8'(int_n_r), 8'h01);
      h.rd(ADDR_STAT1, d);
      check(d, 8'h02);
      h.wr(ADDR_CONFIG, 8'h03);
      fire(9'h008, 1'b0);
      h.rd(ADDR_STAT1, d);
      check(d, 8'h01);
      fire(9'h008, 1'b0);
      wait1();
      check(8'(int_n_r), 8'h00);
      h.wr(ADDR_CONFIG, 8'h13);
      check(8'(reset_n_r), 8'h01);
      h.wr(ADDR_MASK2, 8'h80);
      h.wr(ADDR_CONFIG, 8'h13);
      plen(1'b1);
      h.rd(ADDR_CONFIG, d);
      check(d, 8'h03);
      h.wr(ADDR_CONFIG, 8'h43);
      check(8'(intrusion_out_r), 8'h00);
      plen(1'b0);
      h.wr(ADDR_CONFIG, 8'h80);
      check(8'(soft_init_r), 8'h01);
      h.rd(ADDR_CONFIG, d);
      check(d, CONFIG_RST);
      h.rd(ADDR_MASK2, d);
      check(d, 8'h00);
      h.rd(ADDR_STAT1, d);
      check(d, 8'h00);
      // second reset in mid-run
      h.wr(ADDR_COMPAT, 8'hC3);
      @(posedge clk) #1 nrst = 1'b0;
      repeat (2) @(posedge clk);
      #1 nrst = 1'b1;
      h.rd(ADDR_COMPAT, d);
      check(d, COMPAT_RST);
      h.rd(ADDR_CONFIG, d);
      check(d, CONFIG_RST);
      end_sim();
   end
endmodule : monitor_config_interrupt_control_tb
